// ===== pkg/usb_ev_pkg.sv
/*
  Constants for the low-speed USB event and control block: register
  offsets, field positions, reset values, state codes and timing.
  Assumes a 10 MHz block clock and byte offsets on a 32-bit APB.
*/
package usb_ev_pkg;

  // ==========
  // Register map (byte addresses)
  localparam logic [7:0] OFS_TOKEN = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_MASKS = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_NODE = 8'h10;
  localparam logic [7:0] OFS_INDEX = 8'h14;
  localparam logic [7:0] OFS_EPTX0 = 8'h18;
  localparam logic [7:0] OFS_RXST = 8'h24;
  localparam logic [7:0] EP_STRIDE = 8'h04;
  localparam int EP_COUNT = 3;

  // ==========
  // Event flag positions
  localparam int FLG_SLEEP = 7;
  localparam int FLG_DMA = 6;
  localparam int FLG_GOOD = 5;
  localparam int FLG_ERR = 4;
  localparam int FLG_OVF = 3;
  localparam int FLG_WAKE = 2;
  localparam int FLG_RST = 1;
  localparam int FLG_SOF = 0;

  // ==========
  // Control bits and reset values
  localparam int CTL_RESUME = 3;
  localparam int CTL_REGOFF = 2;
  localparam int CTL_SLEEP = 1;
  localparam int CTL_RESTART = 0;
  localparam logic [7:0] CTRL_RESET = 8'h06;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] MASKS_RESET = 8'h00;
  localparam logic [6:0] NODE_RESET = 7'h00;
  localparam logic [7:0] EPTX_RESET = 8'h00;
  localparam logic [1:0] RXST_RESET = 2'h0;

  // ==========
  // Endpoint fields and token codes
  localparam int EPTX_STOUT = 7;
  localparam int EPTX_STAT_LO = 4;
  localparam logic [1:0] STAT_NAK = 2'h2;
  localparam logic [1:0] PID_OUT = 2'h0;
  localparam logic [1:0] PID_IN = 2'h2;
  localparam logic [1:0] PID_SETUP = 2'h3;
  localparam logic [1:0] PID_LOW_FIXED = 2'h1;

  // ==========
  // Timing
  localparam int CLK_RATE_MHZ = 10;
  localparam int IDLE_TIME_US = 3000;
  localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_RATE_MHZ;

  typedef enum logic [1:0] {
    LS_ACTIVE = 2'h0,
    LS_SUSPENDED = 2'h1,
    LS_RESUMING = 2'h3
  } link_state_t;

  // Zeros clear, ones keep; hardware sets always win
  function automatic logic [7:0] keep_or_set(
    input logic [7:0] old,
    input logic [7:0] wr,
    input logic [7:0] setv
  );
    keep_or_set = (old & wr) | setv;
  endfunction

  function automatic logic valid_ep(input logic [1:0] ep);
    valid_ep = (int'(ep) < EP_COUNT);
  endfunction

endpackage

// ===== pkg/line_if.sv
/*
  Carrier between the line synchroniser, the idle timer and the core.
  Assumes all members are on the single block clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface line_if;
  logic se0;
  logic kstate;
  logic idle;
  logic activity;
  logic armed;
  logic hit;
  modport sync_mp (output se0, output kstate);
  modport timer_mp (input se0, input kstate, input armed,
                    output idle, output activity, output hit);
  modport core_mp (input se0, input kstate, input idle,
                   input activity, input hit, output armed);
endinterface
`default_nettype wire

// ===== verilog/line_sync.sv
/*
  Two-stage synchroniser for the transceiver SE0 and K-state outputs.
  Assumes the pins are asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module line_sync
  import usb_ev_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic se0_pin,
  input wire logic k_pin,
  line_if.sync_mp lines
);
  logic [1:0] meta;
  logic [1:0] stable;
  logic [1:0] next_meta;
  logic [1:0] next_stable;

  always_comb begin
    next_meta = {se0_pin, k_pin};
    next_stable = meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 2'h0;
      stable <= 2'h0;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
    end
  end

  assign lines.se0 = stable[1];
  assign lines.kstate = stable[0];
endmodule
`default_nettype wire

// ===== verilog/idle_timer.sv
/*
  Counts bus idle (J state) time and pulses once when the idle time
  exceeds the limit while armed. Assumes synchronised line inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module idle_timer
  import usb_ev_pkg::*;
#(
  parameter int CYCLES = IDLE_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  line_if.timer_mp lines
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic hit;
  logic next_hit;
  logic idle;

  if (CYCLES < 2) begin : g_chk
    $error("idle_timer: CYCLES must be at least 2");
  end

  // J state: neither SE0 nor K
  assign idle = ~lines.se0 & ~lines.kstate;

  always_comb begin
    next_count = count;
    next_hit = 1'b0;
    if (!idle || !lines.armed) begin
      next_count = '0;
    end else if (count != LIMIT) begin
      next_count = count + CW'(1);
      // Fires once per idle stretch; count then rests at the limit
      next_hit = (next_count == LIMIT);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      hit <= 1'b0;
    end else begin
      count <= next_count;
      hit <= next_hit;
    end
  end

  assign lines.idle = idle;
  assign lines.activity = ~idle;
  assign lines.hit = hit;
endmodule
`default_nettype wire

// ===== verilog/usb_event_ctrl.sv
/*
  Status, event and control registers of a low-speed USB function,
  reached over APB. Assumes the serial engine supplies same-clock
  pulses and levels, and the transceiver lines arrive asynchronously.
*/
// Summary of operation
// - Expose upper two token PID bits; 00 OUT, 10 IN, 11 SETUP.
// - Token register bits 5:3 and 0 read zero.
// - Token register bit 2 shows live SE0 line state.
// - Token register bit 1 shows differential receiver, 1 for K.
// - Hardware sets event flags; software only clears them.
// - Idle over 3 ms raises sleep request; armed by bus reset.
// - Late DMA service sets event bit 6.
// - Correct transfer sets bit 5, keeps token type and endpoint.
// - Correct means no PID, CRC, toggle, overrun, stuff, frame error, and no NAK/STALL sent.
// - Timeout, CRC, stuffing or framing error sets bit 4.
// - Setting error or frame flag again while set sets bit 3.
// - Activity during suspend sets bit 2, on its own vector.
// - Bus reset sets bit 1 and resets address and endpoints.
// - Keep-alive strobe or resume end sets bit 0.
// - Interrupt when flag and mask set and global disable clear.
// - Resume bit 3 drives resume signalling while set.
// - Power-down bit turns the regulator off.
// - Forced sleep enters suspend; activity clears it.
// - Forced restart holds bus reset; clearing raises reset event.
// - Seven-bit address, bit 7 zero, cleared by any bus reset.
// - Status-out bit stalls nonzero-length OUT on that endpoint.
// - Two-bit endpoint field names the endpoint needing attention.
// - Correct IN/SETUP NAKs transmit; correct OUT/SETUP NAKs receive.
`timescale 1ns/1ps
`default_nettype none
module usb_event_ctrl
  import usb_ev_pkg::*;
#(
  parameter int IDLE_LIMIT = IDLE_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic se0_pin,
  input wire logic k_pin,
  input wire logic token_seen,
  input wire logic [3:0] token_pid,
  input wire logic xfer_done,
  input wire logic [1:0] xfer_ep,
  input wire logic pid_ok,
  input wire logic crc_ok,
  input wire logic toggle_ok,
  input wire logic data_overrun,
  input wire logic stuff_err,
  input wire logic frame_err,
  input wire logic nak_stall_sent,
  input wire logic timeout_err,
  input wire logic dma_late,
  input wire logic keepalive,
  input wire logic bus_reset_seen,
  input wire logic [1:0] out_ep,
  input wire logic out_nonzero,
  input wire logic cpu_irq_disable,
  output logic irq,
  output logic wake_irq,
  output logic resume_drive,
  output logic regulator_off,
  output logic restart_hold,
  output logic out_stall
);
  // ==========
  // Line conditioning and idle timer
  line_if lines ();

  line_sync u_sync (
    .clk(clk),
    .rst(rst),
    .se0_pin(se0_pin),
    .k_pin(k_pin),
    .lines(lines)
  );

  idle_timer #(.CYCLES(IDLE_LIMIT)) u_idle (
    .clk(clk),
    .rst(rst),
    .lines(lines)
  );

  // ==========
  // State
  logic [1:0] token_type_bits;
  logic [7:0] event_flags;
  logic [7:0] event_masks;
  logic [7:0] bus_control;
  logic [6:0] node_number;
  logic [1:0] endpoint_index;
  logic [7:0] endpoint_tx_control [EP_COUNT];
  logic [1:0] rx_state [EP_COUNT];
  logic restart_q, armed;
  link_state_t lstate;

  logic [1:0] next_token_type_bits;
  logic [7:0] next_event_flags;
  logic [7:0] next_event_masks;
  logic [7:0] next_bus_control;
  logic [6:0] next_node_number;
  logic [1:0] next_endpoint_index;
  logic [7:0] next_endpoint_tx_control [EP_COUNT];
  logic [1:0] next_rx_state [EP_COUNT];
  link_state_t next_lstate;
  logic [31:0] next_prdata;
  logic next_armed, next_irq, next_wake_irq, next_pslverr;

  // ==========
  // Event decode
  logic setup_ph, access_wr, addr_ok, good, err_ev, sof_ev, resume_end;
  logic wake_ev, restart_fall, bus_rst_ev, ep_clear;
  logic [7:0] set_vec, tok_reg;

  assign setup_ph = psel & ~penable;
  assign access_wr = psel & penable & pwrite & addr_ok;

  assign good = xfer_done & pid_ok & crc_ok & toggle_ok & ~data_overrun
                & ~stuff_err & ~frame_err & ~nak_stall_sent;
  assign err_ev = timeout_err
                  | (xfer_done & (~crc_ok | stuff_err | frame_err));
  assign resume_end = (lstate == LS_RESUMING)
                      & ~bus_control[CTL_RESUME] & lines.idle;
  assign sof_ev = keepalive | resume_end;
  assign wake_ev = (lstate == LS_SUSPENDED) & lines.activity;
  assign restart_fall = restart_q & ~bus_control[CTL_RESTART];
  assign bus_rst_ev = bus_reset_seen | restart_fall;
  // Also held clear while restart is forced
  assign ep_clear = bus_reset_seen | bus_control[CTL_RESTART];

  always_comb begin
    set_vec = 8'h00;
    set_vec[FLG_SLEEP] = lines.hit;
    set_vec[FLG_DMA] = dma_late;
    set_vec[FLG_GOOD] = good;
    set_vec[FLG_ERR] = err_ev;
    set_vec[FLG_OVF] = (err_ev & event_flags[FLG_ERR])
                       | (sof_ev & event_flags[FLG_SOF]);
    set_vec[FLG_WAKE] = wake_ev;
    set_vec[FLG_RST] = bus_rst_ev;
    set_vec[FLG_SOF] = sof_ev;
  end

  assign tok_reg = {token_type_bits, 3'h0, lines.se0, lines.kstate, 1'h0};

  // ==========
  // Register file and event logic
  always_comb begin
    next_token_type_bits = token_type_bits;
    next_event_masks = event_masks;
    next_bus_control = bus_control;
    next_node_number = node_number;
    next_endpoint_index = endpoint_index;
    for (int i = 0; i < EP_COUNT; i++) begin
      next_endpoint_tx_control[i] = endpoint_tx_control[i];
      next_rx_state[i] = rx_state[i];
    end

    if (token_seen) begin
      next_token_type_bits = token_pid[3:2];
    end

    if (access_wr && paddr == OFS_FLAGS) begin
      next_event_flags = keep_or_set(event_flags, pwdata[7:0], set_vec);
    end else begin
      next_event_flags = event_flags | set_vec;
    end

    if (access_wr) begin
      if (paddr == OFS_MASKS) begin
        next_event_masks = pwdata[7:0];
      end else if (paddr == OFS_CTRL) begin
        next_bus_control = {4'h0, pwdata[3:0]};
      end else if (paddr == OFS_NODE) begin
        next_node_number = pwdata[6:0];
      end else if (paddr == OFS_RXST) begin
        for (int i = 0; i < EP_COUNT; i++) begin
          next_rx_state[i] = pwdata[2*i +: 2];
        end
      end else begin
        for (int i = 0; i < EP_COUNT; i++) begin
          if (paddr == OFS_EPTX0 + EP_STRIDE * 8'(i)) begin
            next_endpoint_tx_control[i] = pwdata[7:0];
          end
        end
      end
    end

    // Hardware clear of forced sleep on wake-up activity
    if (wake_ev) begin
      next_bus_control[CTL_SLEEP] = 1'b0;
    end

    if (good && valid_ep(xfer_ep)) begin
      next_endpoint_index = xfer_ep;
      if (token_type_bits == PID_IN || token_type_bits == PID_SETUP) begin
        next_endpoint_tx_control[xfer_ep][EPTX_STAT_LO +: 2] = STAT_NAK;
      end
      if (token_type_bits == PID_OUT || token_type_bits == PID_SETUP) begin
        next_rx_state[xfer_ep] = STAT_NAK;
      end
    end

    if (ep_clear) begin
      next_node_number = NODE_RESET;
      for (int i = 0; i < EP_COUNT; i++) begin
        next_endpoint_tx_control[i] = EPTX_RESET;
        next_rx_state[i] = RXST_RESET;
      end
    end

    next_irq = ~cpu_irq_disable
               & |(next_event_flags & event_masks & ~(8'h01 << FLG_WAKE));
    next_wake_irq = ~cpu_irq_disable & next_event_flags[FLG_WAKE]
                    & event_masks[FLG_WAKE];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      token_type_bits <= 2'h0;
      event_flags <= FLAGS_RESET;
      event_masks <= MASKS_RESET;
      bus_control <= CTRL_RESET;
      node_number <= NODE_RESET;
      endpoint_index <= 2'h0;
      for (int i = 0; i < EP_COUNT; i++) begin
        endpoint_tx_control[i] <= EPTX_RESET;
        rx_state[i] <= RXST_RESET;
      end
      restart_q <= 1'b0;
      irq <= 1'b0;
      wake_irq <= 1'b0;
    end else begin
      token_type_bits <= next_token_type_bits;
      event_flags <= next_event_flags;
      event_masks <= next_event_masks;
      bus_control <= next_bus_control;
      node_number <= next_node_number;
      endpoint_index <= next_endpoint_index;
      for (int i = 0; i < EP_COUNT; i++) begin
        endpoint_tx_control[i] <= next_endpoint_tx_control[i];
        rx_state[i] <= next_rx_state[i];
      end
      restart_q <= bus_control[CTL_RESTART];
      irq <= next_irq;
      wake_irq <= next_wake_irq;
    end
  end

  // ==========
  // Suspend tracking
  // Idle check stays off from forced sleep until the resume completes,
  // so a long resume gap cannot raise a fresh sleep request.
  always_comb begin
    next_lstate = lstate;
    next_armed = armed;
    case (lstate)
      LS_ACTIVE: begin
        if (bus_control[CTL_SLEEP]) begin
          next_lstate = LS_SUSPENDED;
          next_armed = 1'b0;
        end
      end
      LS_SUSPENDED: begin
        if (wake_ev || bus_control[CTL_RESUME]) begin
          next_lstate = LS_RESUMING;
        end
      end
      LS_RESUMING: begin
        if (resume_end) begin
          next_lstate = LS_ACTIVE;
          next_armed = 1'b1;
        end
      end
      default: begin
        next_lstate = LS_ACTIVE;
      end
    endcase
    if (bus_rst_ev) begin
      next_lstate = LS_ACTIVE;
      next_armed = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lstate <= LS_ACTIVE;
      armed <= 1'b0;
    end else begin
      lstate <= next_lstate;
      armed <= next_armed;
    end
  end

  assign lines.armed = armed;

  // ==========
  // APB read path: data captured in the setup phase, zero wait
  always_comb begin
    addr_ok = 1'b1;
    next_prdata = 32'h0;
    if (paddr == OFS_TOKEN) begin
      next_prdata[7:0] = tok_reg;
    end else if (paddr == OFS_FLAGS) begin
      next_prdata[7:0] = event_flags;
    end else if (paddr == OFS_MASKS) begin
      next_prdata[7:0] = event_masks;
    end else if (paddr == OFS_CTRL) begin
      next_prdata[7:0] = bus_control;
    end else if (paddr == OFS_NODE) begin
      next_prdata[7:0] = {1'b0, node_number};
    end else if (paddr == OFS_INDEX) begin
      next_prdata[5:4] = endpoint_index;
    end else if (paddr == OFS_RXST) begin
      for (int i = 0; i < EP_COUNT; i++) begin
        next_prdata[2*i +: 2] = rx_state[i];
      end
    end else begin
      addr_ok = 1'b0;
      for (int i = 0; i < EP_COUNT; i++) begin
        if (paddr == OFS_EPTX0 + EP_STRIDE * 8'(i)) begin
          addr_ok = 1'b1;
          next_prdata[7:0] = endpoint_tx_control[i];
        end
      end
    end
    next_pslverr = ~addr_ok;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  assign pready = 1'b1;

  // ==========
  // Bus-facing controls
  assign resume_drive = bus_control[CTL_RESUME];
  assign regulator_off = bus_control[CTL_REGOFF];
  assign restart_hold = bus_control[CTL_RESTART];
  assign out_stall = valid_ep(out_ep) & out_nonzero
                     & endpoint_tx_control[out_ep][EPTX_STOUT];
endmodule
`default_nettype wire

// ===== verif/usb_event_ctrl_monitor.sv
/*
  Port checker for the low-speed USB event and control block.
  Assumes one clock clk and asynchronous active-high rst.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_event_ctrl_monitor
  import usb_ev_pkg::*;
#(
  parameter int IDLE_LIMIT = IDLE_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic se0_pin,
  input wire logic k_pin,
  input wire logic [1:0] out_ep,
  input wire logic out_nonzero,
  input wire logic cpu_irq_disable,
  input wire logic irq,
  input wire logic resume_drive,
  input wire logic regulator_off,
  input wire logic restart_hold,
  input wire logic out_stall
);
  // ==========
  // Helper logic
  logic tok_rd;
  logic ctl_wr;
  logic [7:0] last_ctl;
  logic [7:0] next_last_ctl;
  assign tok_rd = psel && penable && !pwrite && paddr == OFS_TOKEN;
  assign ctl_wr = psel && penable && pwrite && paddr == OFS_CTRL;
  always_comb begin
    next_last_ctl = ctl_wr ? pwdata[7:0] : last_ctl;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_ctl <= CTRL_RESET;
    end else begin
      last_ctl <= next_last_ctl;
    end
  end

  // ==========
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  token_zero_bits_a: assert property (
    tok_rd |-> prdata[5:3] == 3'h0 && !prdata[0] && prdata[31:8] == 24'h0)
    else $error("token reserved bits set");
  se0_status_a: assert property (
    $stable(se0_pin)[*5] ##0 tok_rd |-> prdata[2] == se0_pin)
    else $error("se0 status wrong");
  k_status_a: assert property (
    $stable(k_pin)[*5] ##0 tok_rd |-> prdata[1] == k_pin)
    else $error("k status wrong");
  irq_gate_a: assert property (
    $past(cpu_irq_disable) |-> !irq)
    else $error("irq while globally disabled");
  resume_out_a: assert property (
    ctl_wr |-> ##2 resume_drive == last_ctl[CTL_RESUME])
    else $error("resume output wrong");
  regulator_out_a: assert property (
    ctl_wr |-> ##2 regulator_off == last_ctl[CTL_REGOFF])
    else $error("regulator output wrong");
  restart_out_a: assert property (
    ctl_wr |-> ##2 restart_hold == last_ctl[CTL_RESTART])
    else $error("restart output wrong");
  stall_len_a: assert property (
    !out_nonzero |-> !out_stall)
    else $error("stall on empty out");
  stall_ep_a: assert property (
    out_ep == 2'h3 |-> !out_stall)
    else $error("stall on missing endpoint");
  token_read_c: cover property (tok_rd);
  ctrl_write_c: cover property (ctl_wr);
  irq_rise_c: cover property ($rose(irq));
endmodule
bind usb_event_ctrl usb_event_ctrl_monitor #(.IDLE_LIMIT(IDLE_LIMIT)) mon (
  .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .se0_pin, .k_pin, .out_ep, .out_nonzero, .cpu_irq_disable, .irq,
  .resume_drive, .regulator_off, .restart_hold, .out_stall);
`default_nettype wire

// ===== verif/usb_host_model.sv
/*
  Host and bus side model: line states, tokens, transfers, strobes.
  Assumes tasks are entered just after a rising clk edge.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
  import usb_ev_pkg::*;
(
  input wire logic clk,
  output logic se0_pin,
  output logic k_pin,
  output logic token_seen,
  output logic [3:0] token_pid,
  output logic xfer_done,
  output logic [1:0] xfer_ep,
  output logic [6:0] qual,
  output logic keepalive,
  output logic bus_reset_seen,
  output logic timeout_err
);
  // ==========
  // Drivers
  initial begin
    {se0_pin, k_pin, token_seen, xfer_done, keepalive} = '0;
    {bus_reset_seen, timeout_err, token_pid, xfer_ep, qual} = '0;
  end
  task automatic line(input logic s, input logic k);
    se0_pin <= s;
    k_pin <= k;
  endtask
  // Released fields flip so stale values never look valid
  task automatic token(input logic [1:0] t);
    token_pid <= {t, PID_LOW_FIXED};
    token_seen <= 1'h1;
    @(posedge clk);
    token_seen <= 1'h0;
    token_pid <= {~t, 2'h2};
  endtask
  task automatic xfer(input logic [1:0] ep, input logic [6:0] q);
    xfer_ep <= ep;
    qual <= q;
    xfer_done <= 1'h1;
    @(posedge clk);
    xfer_done <= 1'h0;
    xfer_ep <= ~ep;
    qual <= ~q;
  endtask
  // Order: keepalive, bus reset, timeout
  task automatic pulse(input logic [2:0] w);
    {keepalive, bus_reset_seen, timeout_err} <= w;
    @(posedge clk);
    {keepalive, bus_reset_seen, timeout_err} <= 3'h0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ===== verif/usb_lowspeed_event_control_bench.sv
/*
  Self-checking bench: APB master, host model, port comparisons.
  Assumes the idle limit shortened to LIM cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_lowspeed_event_control_bench
  import usb_ev_pkg::*;
;
  // ==========
  // Signals and instances
  localparam int LIM = 20;
  localparam logic [6:0] GOOD = 7'h70;
  logic clk, rst, psel, penable, pwrite, dma_late, cpu_irq_disable;
  logic out_nonzero, slv;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [1:0] out_ep;
  wire [31:0] prdata;
  wire pready, pslverr, irq, wake_irq, resume_drive, regulator_off;
  wire restart_hold, out_stall, se0_pin, k_pin, token_seen, xfer_done;
  wire keepalive, bus_reset_seen, timeout_err, pid_ok, crc_ok, toggle_ok;
  wire data_overrun, stuff_err, frame_err, nak_stall_sent;
  wire [3:0] token_pid;
  wire [1:0] xfer_ep;
  int bad_count, n_checks;
  usb_event_ctrl #(.IDLE_LIMIT(LIM)) i_dut (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .se0_pin, .k_pin,
    .token_seen, .token_pid, .xfer_done, .xfer_ep, .pid_ok, .crc_ok,
    .toggle_ok, .data_overrun, .stuff_err, .frame_err, .nak_stall_sent,
    .timeout_err, .dma_late, .keepalive, .bus_reset_seen, .out_ep,
    .out_nonzero, .cpu_irq_disable, .irq, .wake_irq, .resume_drive,
    .regulator_off, .restart_hold, .out_stall);
  usb_host_model host (.clk, .se0_pin, .k_pin, .token_seen, .token_pid,
    .xfer_done, .xfer_ep, .keepalive, .bus_reset_seen, .timeout_err,
    .qual({pid_ok, crc_ok, toggle_ok, data_overrun, stuff_err, frame_err,
           nak_stall_sent}));

  // ==========
  // Shared tasks
  task automatic end_of_test;
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] g,
                     input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] r);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      end_of_test();
    end
    r = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'h1, a, d, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string s);
    logic [31:0] r;
    apb(1'h0, a, 8'h00, r);
    chk(s, r, e);
  endtask
  task automatic so(input logic [1:0] ep, input logic nz, input logic e);
    out_ep <= ep;
    out_nonzero <= nz;
    repeat (2) @(posedge clk);
    chk("out stall", 32'(out_stall), 32'(e));
  endtask

  // ==========
  // Scenarios
  task automatic t_reset;
    chk("regulator", 32'(regulator_off), 32'h1);
    rc(OFS_CTRL, 32'h06, "control");
    rc(OFS_FLAGS, 32'h00, "flags");
    rc(OFS_MASKS, 32'h00, "masks");
    rc(OFS_NODE, 32'h00, "address");
    wr(OFS_CTRL, 8'h00);
  endtask
  task automatic t_tokens;
    logic [1:0] t [3] = '{PID_OUT, PID_IN, PID_SETUP};
    foreach (t[i]) begin
      host.token(t[i]);
      rc(OFS_TOKEN, {24'h0, t[i], 6'h00}, "token type");
    end
    host.line(1'h1, 1'h0);
    repeat (5) @(posedge clk);
    rc(OFS_TOKEN, 32'hC4, "se0 state");
    host.line(1'h0, 1'h1);
    repeat (5) @(posedge clk);
    rc(OFS_TOKEN, 32'hC2, "k state");
    host.line(1'h0, 1'h0);
    // Idle wait before flag checks; the resume end just before arms the idle timer, so a sleep request is raised
    repeat (LIM + 10) @(posedge clk);
  endtask
  task automatic t_good;
    wr(OFS_MASKS, 8'hFF);
    wr(OFS_FLAGS, 8'h00);
    host.token(PID_IN);
    host.xfer(2'h1, GOOD);
    @(posedge clk);
    chk("irq", 32'(irq), 32'h1);
    rc(OFS_FLAGS, 32'h20, "good flag");
    rc(OFS_INDEX, 32'h10, "endpoint index");
    rc(OFS_EPTX0 + EP_STRIDE, 32'h20, "tx nak");
    cpu_irq_disable <= 1'h1;
    repeat (2) @(posedge clk);
    chk("irq disabled", 32'(irq), 32'h0);
    cpu_irq_disable <= 1'h0;
    host.token(PID_SETUP);
    host.xfer(2'h0, GOOD);
    host.token(PID_OUT);
    host.xfer(2'h2, GOOD);
    rc(OFS_EPTX0, 32'h20, "setup tx nak");
    rc(OFS_EPTX0 + 8'h08, 32'h00, "out tx kept");
    rc(OFS_RXST, 32'h22, "rx nak");
    rc(OFS_INDEX, 32'h20, "last endpoint");
    wr(OFS_FLAGS, 8'hFF);
    rc(OFS_FLAGS, 32'h20, "ones keep");
    wr(OFS_FLAGS, 8'hDF);
    rc(OFS_FLAGS, 32'h00, "zero clears");
    for (int i = 0; i < 7; i++) begin
      host.token(PID_IN);
      host.xfer(2'h1, GOOD ^ (7'h1 << i));
    end
    rc(OFS_FLAGS, 32'h18, "bad transfers");
  endtask
  task automatic t_events;
    wr(OFS_FLAGS, 8'h00);
    host.pulse(3'h1);
    rc(OFS_FLAGS, 32'h10, "error flag");
    host.pulse(3'h1);
    host.pulse(3'h4);
    rc(OFS_FLAGS, 32'h19, "overflow and frame");
    dma_late <= 1'h1;
    @(posedge clk);
    dma_late <= 1'h0;
    rc(OFS_FLAGS, 32'h59, "dma late");
  endtask
  task automatic t_ctrl;
    wr(OFS_CTRL, 8'h0C);
    repeat (2) @(posedge clk);
    chk("resume", 32'(resume_drive), 32'h1);
    chk("regulator off", 32'(regulator_off), 32'h1);
    wr(OFS_FLAGS, 8'h00);
    wr(OFS_CTRL, 8'h02);
    repeat (6) @(posedge clk);
    chk("regulator on", 32'(regulator_off), 32'h0);
    host.line(1'h0, 1'h1);
    repeat (6) @(posedge clk);
    chk("wake irq", 32'(wake_irq), 32'h1);
    rc(OFS_CTRL, 32'h00, "sleep cleared");
    rc(OFS_FLAGS, 32'h04, "wake flag");
    host.line(1'h0, 1'h0);
    wr(OFS_EPTX0 + 8'h08, 8'h80);
    so(2'h2, 1'h1, 1'h1);
    so(2'h2, 1'h0, 1'h0);
    so(2'h3, 1'h1, 1'h0);
    so(2'h1, 1'h1, 1'h0);
    rc(8'h40, 32'h00, "unmapped data");
    chk("slave error", 32'(slv), 32'h1);
  endtask
  task automatic t_bus_reset;
    wr(OFS_NODE, 8'h85);
    rc(OFS_NODE, 32'h05, "address");
    wr(OFS_EPTX0 + EP_STRIDE, 8'h3F);
    host.line(1'h0, 1'h1);
    repeat (4) @(posedge clk);
    host.line(1'h0, 1'h0);
    repeat (4) @(posedge clk);
    wr(OFS_FLAGS, 8'h00);
    host.pulse(3'h2);
    rc(OFS_NODE, 32'h00, "address reset");
    rc(OFS_EPTX0 + EP_STRIDE, 32'h00, "endpoint reset");
    repeat (LIM + 10) @(posedge clk);
    rc(OFS_FLAGS, 32'h82, "sleep request");
    wr(OFS_NODE, 8'h12);
    wr(OFS_CTRL, 8'h01);
    repeat (2) @(posedge clk);
    chk("restart hold", 32'(restart_hold), 32'h1);
    rc(OFS_NODE, 32'h00, "address forced");
    wr(OFS_FLAGS, 8'h00);
    wr(OFS_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    rc(OFS_FLAGS, 32'h02, "restart event");
  endtask

  // ==========
  // Clock, watchdog, main sequence
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, dma_late, cpu_irq_disable, out_nonzero} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    out_ep = 2'h0;
    rst = 1'h1;
    bad_count = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    t_reset();
    t_tokens();
    t_good();
    t_events();
    t_ctrl();
    t_bus_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
